// *** design/dtdt_decoder.sv ***
// Registered decoder and least-time model for the transfer instruction group.
`timescale 1ns/1ps
`default_nettype none
module dtdt_decoder #(
  parameter bit BYTE_BUS = 1'b0
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire dtdt_pkg::dtdt_req_s i_req,
  output dtdt_pkg::dtdt_dec_s o_dec,
  output logic [2:0] o_queue_bytes
);
  import dtdt_pkg::*;

  typedef struct packed {
    dtdt_dec_s dec;
  } dtdt_state_s;

  dtdt_state_s state;
  dtdt_state_s next_state;
  dtdt_op_e op;
  logic has_modrm;
  logic mem;
  logic [5:0] base_cycles;

  // Counts are least figures under ideal queue and bus conditions.
  always_comb begin
    op = DTDT_NONE;
    has_modrm = 1'b1;
    case (i_req.opcode)
      OP_SEG_LOAD: op = DTDT_COPY_TRANSFER_TO_SEG;
      OP_SEG_STORE: op = DTDT_COPY_TRANSFER_FROM_SEG;
      OP_LFP_DATA: op = DTDT_LOAD_FAR_POINTER_DATA;
      OP_LFP_EXTRA: op = DTDT_LOAD_FAR_POINTER_EXTRA;
      OP_EA_LOAD: op = DTDT_EFFECTIVE_OFFSET_LOAD;
      OP_FLAGS_TO_HIGH: begin
        op = DTDT_FLAGS_TO_HIGH_ACC;
        has_modrm = 1'b0;
      end
      OP_HIGH_TO_FLAGS: begin
        op = DTDT_HIGH_ACC_TO_FLAGS;
        has_modrm = 1'b0;
      end
      default: has_modrm = 1'b0;
    endcase
  end

  assign mem = has_modrm && (i_req.modrm[MOD_POS +: 2] != MOD_REG);

  dtdt_cycle_table u_table (
    .i_op(op),
    .i_mem(mem),
    .i_byte_bus(BYTE_BUS),
    .o_cycles(base_cycles)
  );

  always_comb begin
    next_state = state;
    next_state.dec.valid = i_req.valid;
    if (i_req.valid) begin
      next_state.dec.op = op;
      next_state.dec.mem_operand = mem;
      next_state.dec.mod_field = has_modrm ? i_req.modrm[MOD_POS +: 2] : 2'h0;
      next_state.dec.reg_field = has_modrm ? i_req.modrm[REG_POS +: 3] : 3'h0;
      next_state.dec.rm_field = has_modrm ? i_req.modrm[2:0] : 3'h0;
      next_state.dec.modrm_bytes = has_modrm ? 2'h1 : 2'h0;
      // Segment moves and pointer loads move words; the flag transfers
      // touch a byte. The width bit stands in opcode bit 0 where present.
      next_state.dec.word_op = (op == DTDT_COPY_TRANSFER_TO_SEG ||
                                op == DTDT_COPY_TRANSFER_FROM_SEG ||
                                op == DTDT_LOAD_FAR_POINTER_DATA ||
                                op == DTDT_LOAD_FAR_POINTER_EXTRA ||
                                op == DTDT_EFFECTIVE_OFFSET_LOAD) ?
                               1'b1 :
                               (op == DTDT_FLAGS_TO_HIGH_ACC ||
                                op == DTDT_HIGH_ACC_TO_FLAGS) ?
                               1'b0 : i_req.opcode[0];
      // Pointer loads with a register operand are not legal encodings.
      next_state.dec.illegal = (op == DTDT_NONE) ||
        ((op == DTDT_LOAD_FAR_POINTER_DATA ||
          op == DTDT_LOAD_FAR_POINTER_EXTRA) && !mem);
      // No opcode here transfers control, so no destination fetch is added.
      next_state.dec.min_cycles = base_cycles;
      // Memory forms may run up to two clocks long from the unit handoff.
      next_state.dec.max_cycles = mem ?
        base_cycles + {4'h0, CYC_HANDOFF_MAX} : base_cycles;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_dec = state.dec;
  // The byte-bus word penalty is folded into the byte-bus table entries.
  assign o_queue_bytes = BYTE_BUS ? 3'(QUEUE_BYTES_BBUS) :
                                    3'(QUEUE_BYTES_WBUS);
endmodule : dtdt_decoder
`default_nettype wire

// *** design/dtdt_pkg.sv ***
// Package with opcodes, cycle counts and record types of the transfer decoder.
// How it works
// - Each count given is the least time, with operands queued, no waits, no hold and aligned words.
// - A memory access may take one or two clocks more than the least count from the unit handoff.
// - On the byte-bus variant counts are for bytes and each word memory transfer adds four clocks.
// - The word-bus variant has a six-byte prefetch queue.
// - The byte-bus variant has a four-byte prefetch queue.
// - Jump and call counts include fetching the next opcode at the target.
// - Opcode 8e moves a register or memory operand into a segment register in 2 or 9/13 clocks.
// - Opcode 8c moves a segment register to a register or memory in 2 or 11/15 clocks.
// - Opcode c5 loads a far pointer and the data segment in 18 or 26 clocks, memory only.
// - Opcode c4 loads a far pointer and the extra segment in 18 or 26 clocks, memory only.
// - Opcode 8d loads the effective address into a register in 6 clocks.
// - Opcode 9f copies the low flags to the high accumulator byte in 2 clocks.
// - Opcode 9e stores the high accumulator byte into the low flags in 3 clocks.
package dtdt_pkg;
  localparam logic [7:0] OP_SEG_LOAD = 8'h8e;
  localparam logic [7:0] OP_SEG_STORE = 8'h8c;
  localparam logic [7:0] OP_LFP_DATA = 8'hc5;
  localparam logic [7:0] OP_LFP_EXTRA = 8'hc4;
  localparam logic [7:0] OP_EA_LOAD = 8'h8d;
  localparam logic [7:0] OP_FLAGS_TO_HIGH = 8'h9f;
  localparam logic [7:0] OP_HIGH_TO_FLAGS = 8'h9e;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam int MOD_POS = 6;
  localparam int REG_POS = 3;
  localparam logic [5:0] CYC_SEG_REG = 6'h02;
  localparam logic [5:0] CYC_SEG_LOAD_MEM_W = 6'h09;
  localparam logic [5:0] CYC_SEG_LOAD_MEM_B = 6'h0d;
  localparam logic [5:0] CYC_SEG_STORE_MEM_W = 6'h0b;
  localparam logic [5:0] CYC_SEG_STORE_MEM_B = 6'h0f;
  localparam logic [5:0] CYC_LFP_W = 6'h12;
  localparam logic [5:0] CYC_LFP_B = 6'h1a;
  localparam logic [5:0] CYC_EA_LOAD = 6'h06;
  localparam logic [5:0] CYC_FLAGS_TO_HIGH = 6'h02;
  localparam logic [5:0] CYC_HIGH_TO_FLAGS = 6'h03;
  localparam logic [5:0] CYC_WORD_PENALTY = 6'h04;
  localparam logic [1:0] CYC_HANDOFF_MAX = 2'h2;
  localparam int QUEUE_BYTES_WBUS = 6;
  localparam int QUEUE_BYTES_BBUS = 4;

  typedef enum logic [3:0] {
    DTDT_NONE = 4'h0,
    DTDT_COPY_TRANSFER_TO_SEG = 4'h1,
    DTDT_COPY_TRANSFER_FROM_SEG = 4'h2,
    DTDT_LOAD_FAR_POINTER_DATA = 4'h3,
    DTDT_LOAD_FAR_POINTER_EXTRA = 4'h4,
    DTDT_EFFECTIVE_OFFSET_LOAD = 4'h5,
    DTDT_FLAGS_TO_HIGH_ACC = 4'h6,
    DTDT_HIGH_ACC_TO_FLAGS = 4'h7
  } dtdt_op_e;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] modrm;
  } dtdt_req_s;

  typedef struct packed {
    logic valid;
    dtdt_op_e op;
    logic illegal;
    logic mem_operand;
    logic word_op;
    logic [1:0] mod_field;
    logic [2:0] reg_field;
    logic [2:0] rm_field;
    logic [5:0] min_cycles;
    logic [5:0] max_cycles;
    logic [1:0] modrm_bytes;
  } dtdt_dec_s;
endpackage : dtdt_pkg

// *** design/dtdt_cycle_table.sv ***
// Lookup of least cycle count per decoded operation and bus variant.
`timescale 1ns/1ps
`default_nettype none
module dtdt_cycle_table (
  input wire dtdt_pkg::dtdt_op_e i_op,
  input wire logic i_mem,
  input wire logic i_byte_bus,
  output logic [5:0] o_cycles
);
  import dtdt_pkg::*;

  always_comb begin
    o_cycles = 6'h00;
    case (i_op)
      DTDT_COPY_TRANSFER_TO_SEG: begin
        o_cycles = !i_mem ? CYC_SEG_REG :
                   (i_byte_bus ? CYC_SEG_LOAD_MEM_B : CYC_SEG_LOAD_MEM_W);
      end
      DTDT_COPY_TRANSFER_FROM_SEG: begin
        o_cycles = !i_mem ? CYC_SEG_REG :
                   (i_byte_bus ? CYC_SEG_STORE_MEM_B : CYC_SEG_STORE_MEM_W);
      end
      DTDT_LOAD_FAR_POINTER_DATA, DTDT_LOAD_FAR_POINTER_EXTRA: begin
        o_cycles = i_byte_bus ? CYC_LFP_B : CYC_LFP_W;
      end
      DTDT_EFFECTIVE_OFFSET_LOAD: o_cycles = CYC_EA_LOAD;
      DTDT_FLAGS_TO_HIGH_ACC: o_cycles = CYC_FLAGS_TO_HIGH;
      DTDT_HIGH_ACC_TO_FLAGS: o_cycles = CYC_HIGH_TO_FLAGS;
      default: o_cycles = 6'h00;
    endcase
  end
endmodule : dtdt_cycle_table
`default_nettype wire

// *** dv/dtdt_decoder_asserts.sv ***
// Checker for the transfer decoder ports.
`timescale 1ns/1ps
`default_nettype none
module dtdt_decoder_asserts import dtdt_pkg::*; #(
  parameter bit BYTE_BUS = 1'b0
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire dtdt_pkg::dtdt_req_s i_req,
  input wire dtdt_pkg::dtdt_dec_s o_dec,
  input wire logic [2:0] o_queue_bytes
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_mem(logic [7:0] o);
    i_req.valid && i_req.opcode == o && i_req.modrm[7:6] != 2'h3;
  endsequence
  property p_answer;
    i_req.valid |=> o_dec.valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_queue;
    o_queue_bytes == (BYTE_BUS ? 3'h4 : 3'h6);
  endproperty
  a_queue: assert property (p_queue) else $error("queue depth");
  property p_lfp;
    s_mem(8'hc5) |=> o_dec.min_cycles == (BYTE_BUS ? 6'h1a : 6'h12);
  endproperty
  a_lfp: assert property (p_lfp) else $error("far load count");
  property p_lfp_reg;
    i_req.valid && i_req.opcode[7:1] == 7'h62 && i_req.modrm[7:6] == 2'h3
      |=> o_dec.illegal;
  endproperty
  a_lfp_reg: assert property (p_lfp_reg) else $error("mod 3");
  property p_seg;
    s_mem(8'h8e) |=> o_dec.min_cycles == (BYTE_BUS ? 6'h0d : 6'h09);
  endproperty
  a_seg: assert property (p_seg) else $error("seg count");
  property p_ea;
    i_req.valid && i_req.opcode == 8'h8d |=> o_dec.min_cycles == 6'h06;
  endproperty
  a_ea: assert property (p_ea) else $error("ea count");
  property p_flags;
    i_req.valid && i_req.opcode == 8'h9f
      |=> o_dec.op == DTDT_FLAGS_TO_HIGH_ACC && o_dec.min_cycles == 6'h02;
  endproperty
  a_flags: assert property (p_flags) else $error("flags op");
  property p_max;
    o_dec.valid && o_dec.mem_operand |-> o_dec.max_cycles == o_dec.min_cycles + 6'h02;
  endproperty
  a_max: assert property (p_max) else $error("max count");
endmodule : dtdt_decoder_asserts
`default_nettype wire

// *** dv/dtdt_queue_model.sv ***
// Prefetch queue model handing whole instructions to the decoder.
`timescale 1ns/1ps
`default_nettype none
module dtdt_queue_model (
  input wire logic i_core_clk,
  input wire logic i_go,
  input wire logic [7:0] i_op,
  input wire logic [7:0] i_modrm,
  output dtdt_pkg::dtdt_req_s o_req
);
  import dtdt_pkg::*;
  // Bytes are already queued; idle bytes are inverted so stale data shows.
  always_ff @(posedge i_core_clk) begin
    o_req <= '{valid: i_go, opcode: i_go ? i_op : ~o_req.opcode,
               modrm: i_go ? i_modrm : ~o_req.modrm};
  end
endmodule : dtdt_queue_model
`default_nettype wire

// *** dv/test_data_transfer_decode_timing.sv ***
// Testbench for the transfer decoder, both bus variants.
`timescale 1ns/1ps
`default_nettype none
module test_data_transfer_decode_timing;
  import dtdt_pkg::*;
  logic i_core_clk = 1'b0, i_arst_n = 1'b0, go = 1'b0;
  logic [7:0] op = 8'h00, mrm = 8'h00;
  logic [2:0] qw, qb;
  dtdt_req_s req;
  dtdt_dec_s dw, db;
  int err_count = 0, checked = 0;
  initial forever #2.5 i_core_clk = ~i_core_clk;
  dtdt_queue_model i_model (.i_core_clk(i_core_clk), .i_go(go), .i_op(op),
    .i_modrm(mrm), .o_req(req));
  dtdt_decoder #(.BYTE_BUS(1'b0)) i_dut (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_req(req), .o_dec(dw), .o_queue_bytes(qw));
  dtdt_decoder #(.BYTE_BUS(1'b1)) i_dut_b (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_req(req), .o_dec(db), .o_queue_bytes(qb));
  task check(input logic c, input string m);
    checked++;
    if (c !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : check
  task issue(input logic [7:0] o, input logic [7:0] r, input dtdt_op_e e,
             input logic il, input logic [5:0] mw, input logic [5:0] mb);
    logic nm;
    logic mm;
    logic wd;
    nm = (o == 8'h8e) || (o == 8'h8c) || (o == 8'hc5) || (o == 8'hc4) ||
      (o == 8'h8d);
    mm = nm && (r[7:6] != 2'h3);
    wd = nm ? 1'b1 : ((o == 8'h9e || o == 8'h9f) ? 1'b0 : o[0]);
    @(posedge i_core_clk);
    go <= 1'b1;
    op <= o;
    mrm <= r;
    @(posedge i_core_clk);
    go <= 1'b0;
    @(posedge i_core_clk);
    #1;
    check(dw.valid === 1'b1 && db.valid === 1'b1, "no answer");
    check(dw.illegal === il && db.illegal === il, "illegal flag");
    if (!il) check(dw.op === e && db.op === e && dw.min_cycles === mw
      && db.min_cycles === mb, "op or count");
    if (!il) check(dw.max_cycles === (mm ? mw + 6'h02 : mw) &&
      db.max_cycles === (mm ? mb + 6'h02 : mb), "max count");
    check(dw.mem_operand === mm && db.mem_operand === mm, "memory form");
    check(dw.mod_field === (nm ? r[7:6] : 2'h0) && dw.reg_field ===
      (nm ? r[5:3] : 3'h0) && dw.rm_field === (nm ? r[2:0] : 3'h0) &&
      dw.modrm_bytes === {1'b0, nm} && db.rm_field === dw.rm_field,
      "operand fields");
    check(dw.word_op === wd && db.word_op === wd, "width bit");
  endtask : issue
  task test_seg;
    issue(8'h8e, 8'hc0, DTDT_COPY_TRANSFER_TO_SEG, 0, 6'h02, 6'h02);
    issue(8'h8e, 8'h06, DTDT_COPY_TRANSFER_TO_SEG, 0, 6'h09, 6'h0d);
    issue(8'h8c, 8'hd8, DTDT_COPY_TRANSFER_FROM_SEG, 0, 6'h02, 6'h02);
    issue(8'h8c, 8'h46, DTDT_COPY_TRANSFER_FROM_SEG, 0, 6'h0b, 6'h0f);
    $display("test_seg done");
  endtask : test_seg
  task test_lfp;
    issue(8'hc5, 8'h16, DTDT_LOAD_FAR_POINTER_DATA, 0, 6'h12, 6'h1a);
    issue(8'hc4, 8'h86, DTDT_LOAD_FAR_POINTER_EXTRA, 0, 6'h12, 6'h1a);
    issue(8'hc5, 8'hc1, DTDT_NONE, 1, 6'h00, 6'h00);
    issue(8'hc4, 8'hd8, DTDT_NONE, 1, 6'h00, 6'h00);
    $display("test_lfp done");
  endtask : test_lfp
  task test_misc;
    issue(8'h8d, 8'h3e, DTDT_EFFECTIVE_OFFSET_LOAD, 0, 6'h06, 6'h06);
    issue(8'h9f, 8'h00, DTDT_FLAGS_TO_HIGH_ACC, 0, 6'h02, 6'h02);
    issue(8'h9e, 8'h00, DTDT_HIGH_ACC_TO_FLAGS, 0, 6'h03, 6'h03);
    check(dw.word_op === 1'b0, "width bit");
    check(qw === 3'h6 && qb === 3'h4, "queue depth");
    issue(8'h91, 8'h00, DTDT_NONE, 1, 6'h00, 6'h00);
    check(dw.op === DTDT_NONE && db.op === DTDT_NONE &&
      dw.min_cycles === 6'h00 && db.max_cycles === 6'h00, "unknown opcode");
    $display("test_misc done");
  endtask : test_misc
  task test_reset;
    issue(8'h8e, 8'h06, DTDT_COPY_TRANSFER_TO_SEG, 0, 6'h09, 6'h0d);
    @(posedge i_core_clk);
    i_arst_n <= 1'b0;
    @(posedge i_core_clk);
    #1;
    check(dw === '0 && db === '0, "reset clear");
    @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    issue(8'h8c, 8'h46, DTDT_COPY_TRANSFER_FROM_SEG, 0, 6'h0b, 6'h0f);
    $display("test_reset done");
  endtask : test_reset
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge i_core_clk);
    check(dw.valid === 1'b0, "reset valid");
    i_arst_n <= 1'b1;
    test_seg();
    test_lfp();
    test_misc();
    test_reset();
    print_verdict();
  end
endmodule : test_data_transfer_decode_timing
bind dtdt_decoder dtdt_decoder_asserts #(.BYTE_BUS(BYTE_BUS)) i_chk (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_req(i_req),
  .o_dec(o_dec), .o_queue_bytes(o_queue_bytes));
`default_nettype wire
